// file: verilog/smf_pkg.sv
// constants and types of the supply monitor fault, gpio and tracking block
package smf_pkg;
    // device clock
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned US_CYC = CLK_HZ / 1_000_000;
    localparam int unsigned US_PER_MS = 1000;
    // documented times, each in its own unit
    localparam int unsigned T_SETUP_TRACK_MS = 32;
    localparam int unsigned T_DEC_TRACK_US = 88;
    localparam int unsigned T_HOLD_TRACK_MS = 32;
    localparam int unsigned T_SYNC_MS = 255;
    localparam int unsigned T_SMB_MS = 32;
    // field widths and counts
    localparam int unsigned TRK_W = 10;
    localparam int unsigned N_DAC = 2;
    localparam int unsigned N_MUX = 7;
    // arbitrary base of the nine strapped slave addresses
    localparam logic [6:0] ADDR_BASE = 7'h40;

    typedef enum logic [1:0] {G0_PG, G0_PG_N, G0_IN, G0_OUT} smf_mode0_t;
    typedef enum logic [1:0] {G1_FAULT, G1_IN, G1_OUT} smf_mode1_t;
    typedef enum logic [1:0] {LVL_GND, LVL_FLOAT, LVL_VDD} smf_level_t;
    typedef enum logic [2:0] {
        CH_S0_SERVO, CH_S0_MON, CH_S1_SERVO, CH_S1_MON, CH_VDD, CH_12V, CH_TEMP
    } smf_chan_t;
    typedef enum logic [1:0] {TRK_IDLE, TRK_OFF_WAIT, TRK_OFF_DEC, TRK_ON_WAIT} smf_state_t;
endpackage : smf_pkg

// file: verilog/smf_tick_if.sv
// microsecond and millisecond enable pulses shared inside the block
`timescale 1ns/1ps
interface smf_tick_if;
    logic tick_us;
    logic tick_ms;
    modport gen (output tick_us, output tick_ms);
    modport use_tick (input tick_us, input tick_ms);
endinterface : smf_tick_if

// file: verilog/smf_prescale.sv
// divider producing one-cycle microsecond and millisecond enables
`timescale 1ns/1ps
module smf_prescale
    import smf_pkg::*;
#(
    parameter int unsigned CYC_PER_US = US_CYC,
    parameter int unsigned US_PER_MS_P = US_PER_MS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    smf_tick_if.gen tk
);
    localparam logic [15:0] US_LIM = 16'(CYC_PER_US - 1);
    localparam logic [15:0] MS_LIM = 16'(US_PER_MS_P - 1);

    logic [15:0] cyc_q;
    logic [15:0] us_q;
    logic tick_us_q;
    logic tick_ms_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cyc_q <= 16'h0000;
            tick_us_q <= 1'b0;
        end else if (cyc_q == US_LIM) begin
            cyc_q <= 16'h0000;
            tick_us_q <= 1'b1;
        end else begin
            cyc_q <= cyc_q + 16'h0001;
            tick_us_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            us_q <= 16'h0000;
            tick_ms_q <= 1'b0;
        end else begin
            tick_ms_q <= 1'b0;
            if (cyc_q == US_LIM) begin
                if (us_q == MS_LIM) begin
                    us_q <= 16'h0000;
                    tick_ms_q <= 1'b1;
                end else begin
                    us_q <= us_q + 16'h0001;
                end
            end
        end
    end

    assign tk.tick_us = tick_us_q;
    assign tk.tick_ms = tick_ms_q;
endmodule : smf_prescale

// file: verilog/smf_top.sv
// fault reporting, open-drain pins, straps, mux select and tracking timers
`timescale 1ns/1ps
module smf_top
    import smf_pkg::*;
#(
    parameter int unsigned N_MON = 6,
    parameter int unsigned US_PER_MS_P = US_PER_MS,
    parameter int unsigned SETUP_MS = T_SETUP_TRACK_MS,
    parameter int unsigned DEC_US = T_DEC_TRACK_US,
    parameter int unsigned HOLD_MS = T_HOLD_TRACK_MS,
    parameter int unsigned SYNC_MS = T_SYNC_MS,
    parameter int unsigned SMB_MS = T_SMB_MS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [N_MON-1:0] over_voltage_fault_i,
    input wire logic [N_MON-1:0] under_voltage_fault_i,
    input wire logic [N_DAC-1:0] dac_rail_i,
    input wire logic alert_dac_en_i,
    input wire logic alert_volt_en_i,
    output logic alert_o,
    output logic alert_oe_o,
    output logic power_good_o,
    input wire smf_mode0_t gpio0_mode_i,
    input wire smf_mode1_t gpio1_mode_i,
    input wire logic gpio_cfg_wr_i,
    input wire logic gpio0_drive_low_i,
    input wire logic gpio1_drive_low_i,
    input wire logic gpio0_i,
    input wire logic gpio1_i,
    output logic gpio0_o,
    output logic gpio0_oe_o,
    output logic gpio1_o,
    output logic gpio1_oe_o,
    output logic gpio0_in_o,
    output logic gpio1_in_o,
    input wire logic pin_default_select_alt_i,
    input wire smf_level_t addr_strap_low_i,
    input wire smf_level_t addr_strap_high_i,
    output logic [6:0] slave_addr_o,
    input wire smf_chan_t adc_chan_i,
    output logic [N_MUX-1:0] mux_sel_o,
    output logic atten_en_o,
    input wire logic adc_done_i,
    input wire logic [N_DAC-1:0] servo_en_i,
    output logic [N_DAC-1:0] servo_step_o,
    input wire logic track_off_i,
    input wire logic track_on_i,
    input wire logic [N_DAC-1:0][TRK_W-1:0] track_delay_init_i,
    output logic [N_DAC-1:0][TRK_W-1:0] tracking_delay_count_o,
    output logic track_busy_o,
    output logic track_done_o,
    output logic dac_disconnect_o,
    input wire logic sync_cmd_i,
    output logic sync_pending_o,
    output logic sync_abort_o,
    input wire logic bus_cmd_start_i,
    input wire logic bus_cmd_done_i,
    output logic bus_busy_o,
    output logic bus_release_o
);
    // waits count whole ms ticks after entry, so they last from N to N+1 ms
    localparam logic [7:0] SETUP_LIM = 8'(SETUP_MS);
    localparam logic [7:0] HOLD_LIM = 8'(HOLD_MS);
    localparam logic [7:0] SYNC_LIM = 8'(SYNC_MS);
    localparam logic [7:0] SMB_LIM = 8'(SMB_MS);
    localparam logic [11:0] DEC_LIM = 12'(DEC_US - 1);

    smf_tick_if tk ();

    smf_prescale #(
        .CYC_PER_US(US_CYC),
        .US_PER_MS_P(US_PER_MS_P)
    ) u_prescale (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tk(tk)
    );

    smf_state_t state_q;
    logic [7:0] wait_q;
    logic [11:0] dec_us_q;
    logic dec_tick;
    logic all_zero;
    logic [N_DAC-1:0][TRK_W-1:0] cnt_q;
    logic track_done_q;
    logic disc_q;

    // ---------------- fault reporting ----------------
    logic volt_fault;
    logic pg_q;
    logic alert_q;
    logic dac_fault_q;
    assign volt_fault = |(over_voltage_fault_i | under_voltage_fault_i);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pg_q <= 1'b0;
            alert_q <= 1'b0;
            dac_fault_q <= 1'b0;
        end else begin
            pg_q <= !volt_fault;
            dac_fault_q <= |dac_rail_i;
            alert_q <= (alert_dac_en_i && |dac_rail_i) || (alert_volt_en_i && volt_fault);
        end
    end
    assign power_good_o = pg_q;
    assign alert_o = 1'b0;
    assign alert_oe_o = alert_q;

    // ---------------- general pins ----------------
    // strap sampled one cycle after reset release, never under reset itself
    logic armed_q;
    logic dflt_q;
    logic g0_oe_q;
    logic g1_oe_q;
    logic g0_in_q;
    logic g1_in_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            armed_q <= 1'b0;
            dflt_q <= 1'b0;
        end else if (!armed_q) begin
            armed_q <= 1'b1;
            dflt_q <= pin_default_select_alt_i;
        end else if (gpio_cfg_wr_i) begin
            dflt_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            g0_oe_q <= 1'b0;
            g1_oe_q <= 1'b0;
        end else begin
            case (gpio0_mode_i)
                G0_PG: g0_oe_q <= dflt_q || !pg_q;
                G0_PG_N: g0_oe_q <= dflt_q || pg_q;
                G0_OUT: g0_oe_q <= dflt_q || gpio0_drive_low_i;
                default: g0_oe_q <= dflt_q;
            endcase
            case (gpio1_mode_i)
                G1_FAULT: g1_oe_q <= dflt_q || dac_fault_q;
                G1_OUT: g1_oe_q <= dflt_q || gpio1_drive_low_i;
                default: g1_oe_q <= dflt_q;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            g0_in_q <= 1'b0;
            g1_in_q <= 1'b0;
        end else begin
            g0_in_q <= gpio0_i;
            g1_in_q <= gpio1_i;
        end
    end
    // pins only ever pull low; the pull-up outside gives the high level
    assign gpio0_o = 1'b0;
    assign gpio1_o = 1'b0;
    assign gpio0_oe_o = g0_oe_q;
    assign gpio1_oe_o = g1_oe_q;
    assign gpio0_in_o = g0_in_q;
    assign gpio1_in_o = g1_in_q;

    // ---------------- address straps and mux ----------------
    logic [6:0] addr_q;
    logic [N_MUX-1:0] mux_q;
    logic atten_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            addr_q <= ADDR_BASE;
            mux_q <= 7'h01;
            atten_q <= 1'b0;
        end else begin
            addr_q <= ADDR_BASE + 7'(3 * int'(addr_strap_high_i) + int'(addr_strap_low_i));
            mux_q <= N_MUX'(7'h01 << adc_chan_i);
            atten_q <= (adc_chan_i == CH_12V);
        end
    end
    assign slave_addr_o = addr_q;
    assign mux_sel_o = mux_q;
    assign atten_en_o = atten_q;

    // ---------------- tracking sequencer ----------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= TRK_IDLE;
            wait_q <= 8'h00;
            track_done_q <= 1'b0;
            disc_q <= 1'b0;
        end else begin
            track_done_q <= 1'b0;
            disc_q <= 1'b0;
            case (state_q)
                TRK_IDLE: begin
                    wait_q <= 8'h00;
                    if (track_off_i) begin
                        state_q <= TRK_OFF_WAIT;
                    end else if (track_on_i) begin
                        state_q <= TRK_ON_WAIT;
                    end
                end
                TRK_OFF_WAIT: begin
                    if (tk.tick_ms) begin
                        if (wait_q == SETUP_LIM) begin
                            state_q <= TRK_OFF_DEC;
                        end else begin
                            wait_q <= wait_q + 8'h01;
                        end
                    end
                end
                TRK_OFF_DEC: begin
                    if (all_zero) begin
                        state_q <= TRK_IDLE;
                        track_done_q <= 1'b1;
                    end
                end
                TRK_ON_WAIT: begin
                    if (tk.tick_ms) begin
                        if (wait_q == HOLD_LIM) begin
                            state_q <= TRK_IDLE;
                            disc_q <= 1'b1;
                        end else begin
                            wait_q <= wait_q + 8'h01;
                        end
                    end
                end
                default: state_q <= TRK_IDLE;
            endcase
        end
    end

    // decrement pacing restarts on entry, so the first step is a full period later
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || state_q != TRK_OFF_DEC) begin
            dec_us_q <= 12'h000;
        end else if (tk.tick_us) begin
            dec_us_q <= (dec_us_q == DEC_LIM) ? 12'h000 : dec_us_q + 12'h001;
        end
    end
    assign dec_tick = (state_q == TRK_OFF_DEC) && tk.tick_us && (dec_us_q == DEC_LIM);

    // per channel: tracking delay count and servo gating
    genvar ch;
    generate
        for (ch = 0; ch < N_DAC; ch++) begin : g_ch
            localparam smf_chan_t SERVO_CH = (ch == 0) ? CH_S0_SERVO : CH_S1_SERVO;
            logic step_q;
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    cnt_q[ch] <= '0;
                end else if (state_q == TRK_IDLE && track_off_i) begin
                    cnt_q[ch] <= track_delay_init_i[ch];
                end else if (dec_tick && cnt_q[ch] != '0) begin
                    cnt_q[ch] <= cnt_q[ch] - TRK_W'(1);
                end
            end
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    step_q <= 1'b0;
                end else begin
                    step_q <= adc_done_i && servo_en_i[ch] && (adc_chan_i == SERVO_CH);
                end
            end
            assign servo_step_o[ch] = step_q;
        end
    endgenerate
    assign all_zero = (cnt_q == '0);
    assign tracking_delay_count_o = cnt_q;
    assign track_busy_o = (state_q != TRK_IDLE);
    assign track_done_o = track_done_q;
    assign dac_disconnect_o = disc_q;

    // ---------------- sync and bus watchdogs ----------------
    logic sync_q;
    logic [7:0] sync_cnt_q;
    logic sync_abort_q;
    logic busy_q;
    logic [7:0] smb_cnt_q;
    logic rel_q;

    // a new sync arming wins over a tracking command in the same cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync_q <= 1'b0;
            sync_cnt_q <= 8'h00;
            sync_abort_q <= 1'b0;
        end else begin
            sync_abort_q <= 1'b0;
            if (sync_cmd_i) begin
                sync_q <= 1'b1;
                sync_cnt_q <= 8'h00;
            end else if (track_on_i || track_off_i) begin
                sync_q <= 1'b0;
            end else if (sync_q && tk.tick_ms) begin
                if (sync_cnt_q == SYNC_LIM) begin
                    sync_q <= 1'b0;
                    sync_abort_q <= 1'b1;
                end else begin
                    sync_cnt_q <= sync_cnt_q + 8'h01;
                end
            end
        end
    end
    assign sync_pending_o = sync_q;
    assign sync_abort_o = sync_abort_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            busy_q <= 1'b0;
            smb_cnt_q <= 8'h00;
            rel_q <= 1'b0;
        end else begin
            rel_q <= 1'b0;
            if (bus_cmd_start_i) begin
                busy_q <= 1'b1;
                smb_cnt_q <= 8'h00;
            end else if (bus_cmd_done_i) begin
                busy_q <= 1'b0;
            end else if (busy_q && tk.tick_ms) begin
                if (smb_cnt_q == SMB_LIM) begin
                    busy_q <= 1'b0;
                    rel_q <= 1'b1;
                end else begin
                    smb_cnt_q <= smb_cnt_q + 8'h01;
                end
            end
        end
    end
    assign bus_busy_o = busy_q;
    assign bus_release_o = rel_q;

    // ---------------- assertions ----------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_pg_nor: assert property ($past(rst_n_i) |-> power_good_o == !$past(volt_fault))
        else $error("power good not NOR of voltage faults");
    a_alert_cause: assert property ($rose(alert_oe_o) |->
        $past((alert_dac_en_i && |dac_rail_i) || (alert_volt_en_i && volt_fault)))
        else $error("alert asserted without cause");
    a_g0_input: assert property (gpio0_mode_i == G0_IN && !dflt_q |=> !gpio0_oe_o)
        else $error("gpio0 input mode drives pin");
    a_g1_fault: assert property (gpio1_mode_i == G1_FAULT && dac_fault_q |=> gpio1_oe_o)
        else $error("gpio1 missing dac fault");
    a_strap_dflt: assert property (armed_q && !$past(armed_q) && dflt_q |=> gpio0_oe_o && gpio1_oe_o)
        else $error("strap default not driving pins");
    a_mux_onehot: assert property ($onehot(mux_sel_o) && (atten_en_o == mux_sel_o[CH_12V]))
        else $error("mux select not one-hot");
    a_mon_no_servo: assert property (adc_done_i && (adc_chan_i == CH_S0_MON || adc_chan_i == CH_S1_MON)
        |=> servo_step_o == '0)
        else $error("monitor channel stepped a dac");
    a_dec_step: assert property (dec_tick && cnt_q[0] != '0 |=> cnt_q[0] == $past(cnt_q[0]) - TRK_W'(1))
        else $error("delay count step wrong");
    a_cnt_sat: assert property (state_q == TRK_OFF_DEC && cnt_q[1] == '0 |=> cnt_q[1] == '0)
        else $error("delay count wrapped");
    a_setup_enter: assert property ($rose(state_q == TRK_OFF_DEC) |-> $past(wait_q) == SETUP_LIM)
        else $error("decrement started early");
    a_disc_wait: assert property (dac_disconnect_o |-> $past(state_q) == TRK_ON_WAIT && $past(wait_q) == HOLD_LIM)
        else $error("disconnect without full wait");
    a_sync_abort: assert property (sync_abort_o |-> !sync_pending_o && $past(sync_cnt_q) == SYNC_LIM)
        else $error("sync abort early");
    a_bus_release: assert property (bus_release_o |-> $past(busy_q) && !bus_busy_o)
        else $error("bus release without command");

    c_track_off: cover property (track_done_o);
    c_track_on: cover property (dac_disconnect_o);
    c_sync_abort: cover property (sync_abort_o);
    c_bus_release: cover property (bus_release_o);
endmodule : smf_top

// file: dv/smf_host_model.sv
// host side model issuing bus commands, completing them promptly or stalling
`timescale 1ns/1ps
module smf_host_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic go_i,
    input wire logic stall_i,
    output logic bus_cmd_start_o,
    output logic bus_cmd_done_o
);
    logic [3:0] cnt_q;
    logic run_q;

    // a stalled host never finishes, so only the device timeout can free the bus
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bus_cmd_start_o <= 1'b0;
            bus_cmd_done_o <= 1'b0;
            run_q <= 1'b0;
            cnt_q <= 4'h0;
        end else begin
            bus_cmd_start_o <= go_i;
            bus_cmd_done_o <= run_q && cnt_q == 4'h1;
            if (go_i) begin
                run_q <= ~stall_i;
                cnt_q <= 4'h8;
            end else if (run_q) begin
                cnt_q <= cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    run_q <= 1'b0;
                end
            end
        end
    end
endmodule : smf_host_model

// file: dv/smf_top_tb_top.sv
// self-checking testbench of the fault, gpio, strap, mux and tracking block
`timescale 1ns/1ps
module smf_top_tb_top;
    import smf_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, ext0 = 1'b1, ext1 = 1'b1, go = 1'b0, stall = 1'b0;
    logic [5:0] ov = 6'h00, uv = 6'h00;
    logic [1:0] rail = 2'h0, servo_en = 2'h0;
    logic den = 1'b0, ven = 1'b0, cfg_wr = 1'b0, dl0 = 1'b0, dl1 = 1'b0, strap = 1'b1, done = 1'b0;
    logic trk_off = 1'b0, trk_on = 1'b0, sync = 1'b0, bstart, bdone;
    smf_mode0_t m0 = G0_IN;
    smf_mode1_t m1 = G1_IN;
    smf_level_t lo = LVL_GND, hi = LVL_GND;
    smf_chan_t chan = CH_S0_SERVO;
    logic [1:0][9:0] init = '0;
    logic alert, alert_oe, pg, g0, g0_oe, g1, g1_oe, g0_in, g1_in, atten, busy, tdone, disc;
    logic spend, sabort, bbusy, brel;
    logic [6:0] addr, msel;
    logic [1:0] step;
    logic [1:0][9:0] cnt;
    wire logic gpio0_pin = g0_oe ? 1'b0 : ext0;
    wire logic gpio1_pin = g1_oe ? 1'b0 : ext1;
    int fail_count = 0, comparisons = 0, n;

    smf_top #(.US_PER_MS_P(4), .SETUP_MS(3), .DEC_US(4), .SYNC_MS(5), .SMB_MS(3)) smf_top_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .over_voltage_fault_i(ov), .under_voltage_fault_i(uv),
        .dac_rail_i(rail), .alert_dac_en_i(den), .alert_volt_en_i(ven), .alert_o(alert),
        .alert_oe_o(alert_oe), .power_good_o(pg), .gpio0_mode_i(m0), .gpio1_mode_i(m1),
        .gpio_cfg_wr_i(cfg_wr), .gpio0_drive_low_i(dl0), .gpio1_drive_low_i(dl1), .gpio0_i(gpio0_pin),
        .gpio1_i(gpio1_pin), .gpio0_o(g0), .gpio0_oe_o(g0_oe), .gpio1_o(g1), .gpio1_oe_o(g1_oe),
        .gpio0_in_o(g0_in), .gpio1_in_o(g1_in), .pin_default_select_alt_i(strap), .addr_strap_low_i(lo),
        .addr_strap_high_i(hi), .slave_addr_o(addr), .adc_chan_i(chan), .mux_sel_o(msel),
        .atten_en_o(atten), .adc_done_i(done), .servo_en_i(servo_en), .servo_step_o(step),
        .track_off_i(trk_off), .track_on_i(trk_on), .track_delay_init_i(init),
        .tracking_delay_count_o(cnt), .track_busy_o(busy), .track_done_o(tdone),
        .dac_disconnect_o(disc), .sync_cmd_i(sync), .sync_pending_o(spend), .sync_abort_o(sabort),
        .bus_cmd_start_i(bstart), .bus_cmd_done_i(bdone), .bus_busy_o(bbusy), .bus_release_o(brel));

    smf_host_model smf_host_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go), .stall_i(stall),
        .bus_cmd_start_o(bstart), .bus_cmd_done_o(bdone));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic settle(input int c);
        repeat (c) @(posedge clk_i);
        @(negedge clk_i);
    endtask : settle

    task automatic finish_test();
        if (fail_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic t_strap_default();
        settle(3);
        check("strap oe0", g0_oe, 1);
        check("strap oe1", g1_oe, 1);
        @(posedge clk_i) cfg_wr <= 1'b1;
        @(posedge clk_i) begin
            cfg_wr <= 1'b0;
            rst_n_i <= 1'b0;
            strap <= 1'b0;
        end
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        settle(3);
        check("nostrap oe0", g0_oe, 0);
        check("nostrap oe1", g1_oe, 0);
    endtask : t_strap_default

    task automatic t_gpio();
        @(posedge clk_i) begin
            m0 <= G0_OUT;
            m1 <= G1_OUT;
            dl0 <= 1'b1;
        end
        settle(3);
        check("out oe0", g0_oe, 1);
        check("out oe1", g1_oe, 0);
        check("out data", {alert, g0, g1}, 0);
        @(posedge clk_i) begin
            dl0 <= 1'b0;
            dl1 <= 1'b1;
        end
        settle(3);
        check("out oe pair", {g0_oe, g1_oe}, 2'b01);
        @(posedge clk_i) begin
            m0 <= G0_IN;
            m1 <= G1_IN;
            dl1 <= 1'b0;
            ext1 <= 1'b0;
        end
        settle(3);
        check("in level", {g0_oe, g1_oe, g0_in, g1_in}, 4'b0010);
        @(posedge clk_i) begin
            ext0 <= 1'b0;
            ext1 <= 1'b1;
        end
        settle(2);
        check("in swap", {g0_in, g1_in}, 2'b01);
        @(posedge clk_i) ext0 <= 1'b1;
    endtask : t_gpio

    // one row of fault inputs and enables with the pin levels expected after settling
    task automatic fault_row(input logic [5:0] o, input logic [5:0] u, input logic [1:0] r, input logic de,
                             input logic ve, input smf_mode0_t md, input logic [3:0] exp);
        @(posedge clk_i) begin
            ov <= o;
            uv <= u;
            rail <= r;
            den <= de;
            ven <= ve;
            m0 <= md;
            m1 <= G1_FAULT;
        end
        settle(3);
        check("fault pins", {pg, alert_oe, g0_oe, g1_oe}, exp);
    endtask : fault_row

    task automatic t_faults();
        fault_row(6'h00, 6'h00, 2'b00, 1, 1, G0_PG, 4'b1000);
        fault_row(6'h00, 6'h00, 2'b01, 1, 1, G0_PG, 4'b1101);
        fault_row(6'h00, 6'h00, 2'b10, 0, 1, G0_PG, 4'b1001);
        fault_row(6'h00, 6'h20, 2'b00, 1, 1, G0_PG, 4'b0110);
        fault_row(6'h01, 6'h00, 2'b00, 1, 0, G0_PG_N, 4'b0000);
        fault_row(6'h00, 6'h00, 2'b00, 1, 1, G0_PG_N, 4'b1010);
    endtask : t_faults

    task automatic t_straps_mux();
        for (int h = 0; h < 3; h++) begin
            for (int l = 0; l < 3; l++) begin
                @(posedge clk_i) begin
                    hi <= smf_level_t'(h);
                    lo <= smf_level_t'(l);
                end
                settle(2);
                check("slave addr", addr, ADDR_BASE + 7'(3 * h + l));
            end
        end
        for (int c = 0; c < 7; c++) begin
            @(posedge clk_i) chan <= smf_chan_t'(c);
            settle(2);
            check("mux", {atten, msel}, {c == 5, 7'(1 << c)});
        end
    endtask : t_straps_mux

    task automatic t_servo();
        for (int e = 1; e < 4; e++) begin
            for (int c = 0; c < 7; c++) begin
                @(posedge clk_i) begin
                    chan <= smf_chan_t'(c);
                    servo_en <= 2'(e);
                    done <= 1'b1;
                end
                @(posedge clk_i) done <= 1'b0;
                @(negedge clk_i);
                check("servo step", step, (c == 0 ? 2'b01 : c == 2 ? 2'b10 : 2'b00) & 2'(e));
            end
        end
    endtask : t_servo

    task automatic t_track();
        @(posedge clk_i) begin
            init <= {10'd1, 10'd3};
            trk_off <= 1'b1;
        end
        @(posedge clk_i) trk_off <= 1'b0;
        for (n = 0; cnt[0] !== 10'd2 && n < 3000; n++) @(negedge clk_i);
        check("setup wait", n >= 800 && n <= 1002 && busy === 1'b1, 1);
        for (n = 0; cnt[0] !== 10'd1 && n < 3000; n++) @(negedge clk_i);
        check("dec period", n, 200);
        check("stop at zero", cnt[1], 0);
        for (n = 0; tdone !== 1'b1 && n < 3000; n++) @(negedge clk_i);
        check("last dec", n >= 199 && n <= 202 && cnt === '0 && busy === 1'b0, 1);
        @(posedge clk_i) trk_on <= 1'b1;
        @(posedge clk_i) trk_on <= 1'b0;
        // hold wait runs at its full default length of ms ticks, 200 cycles each here
        for (n = 0; disc !== 1'b1 && n < 8000; n++) @(negedge clk_i);
        check("hold wait", n >= 200 * T_HOLD_TRACK_MS && n <= 200 * T_HOLD_TRACK_MS + 205, 1);
    endtask : t_track

    task automatic t_timeouts();
        @(posedge clk_i) sync <= 1'b1;
        @(posedge clk_i) sync <= 1'b0;
        @(negedge clk_i);
        check("sync pending", spend, 1);
        for (n = 0; sabort !== 1'b1 && n < 3000; n++) @(negedge clk_i);
        check("sync abort", n >= 1000 && n <= 1205 && spend === 1'b0, 1);
        @(posedge clk_i) begin
            stall <= 1'b1;
            go <= 1'b1;
        end
        @(posedge clk_i) go <= 1'b0;
        settle(1);
        check("bus busy", bbusy, 1);
        for (n = 0; brel !== 1'b1 && n < 3000; n++) @(negedge clk_i);
        check("bus release", n >= 600 && n <= 805 && bbusy === 1'b0, 1);
        @(posedge clk_i) begin
            stall <= 1'b0;
            go <= 1'b1;
        end
        @(posedge clk_i) go <= 1'b0;
        n = 0;
        repeat (900) begin
            @(negedge clk_i);
            n += (brel === 1'b1);
        end
        check("prompt command", {bbusy, 8'(n)}, 0);
    endtask : t_timeouts

    initial begin
        #600_000;
        fail_count++;
        finish_test();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_strap_default();
        t_gpio();
        t_faults();
        t_straps_mux();
        t_servo();
        t_track();
        t_timeouts();
        finish_test();
    end
endmodule : smf_top_tb_top
